// [hdl/asm_status_regs.sv]
// Status monitor register bank of the amplifier control port
// Behaviour
// - Left sign bit 7: 0 negative
// - Left bits 4-0 common-mode compensator value
// - Right sign bit 7: 0 negative
// - Right bits 4-0 common-mode compensator value
// - Mute field mirrors three-level pin decoder
// - Speed monitor: auto or software mode source
// - Auto encoding: 000 error, 111 reserved
// - Software encoding: 000 reserved, 111 32 kHz
// - Magnitude registers report eight-bit differential magnitude
// - Boot flag bit 7 set after boot
// - Four-bit power state code, 0101 run
`timescale 1ns/1ns
module asm_status_regs (
  input wire logic core_clk, // System clock, 250 MHz
  input wire logic nrst, // Async power-on reset, active low
  input wire asm_pkg::asm_req_type req, // Control port access
  output logic [7:0] rdata, // Registered read data
  output logic rvalid, // Read data valid, one cycle
  input wire asm_pkg::asm_cal_type cal, // Calibration results
  input wire logic mute_above_high, // Mute pin comparator, high
  input wire logic mute_above_mid, // Mute pin comparator, mid
  input wire logic auto_clk_en, // Automatic clock setup active
  input wire logic [2:0] auto_mode, // Detected speed mode
  input wire logic [2:0] sw_mode, // Programmed speed mode
  input wire logic boot_done_flag, // Processor boot complete
  input wire logic [3:0] power_state_code // Converter power state
);
  // ==========================================
  // Declarations
  logic [1:0] mute_level_code;
  logic [2:0] speed_mode_monitor;
  localparam int RSV_ENTRIES = 5; // Registers with writable reserved bits
  logic [RSV_ENTRIES-1:0][7:0] rsv_word;
  logic [RSV_ENTRIES-1:0][7:0] rsv_mask;
  logic [RSV_ENTRIES-1:0] rsv_hit;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] rdata_nxt;
  logic hit_left;
  logic hit_right;
  logic hit_mute;
  logic hit_speed;
  logic hit_boot;
  logic hit_lmag;
  logic hit_rmag;
  logic [7:0] val_left;
  logic [7:0] val_right;
  logic [7:0] val_mute;
  logic [7:0] val_speed;
  logic [7:0] val_boot;

  // ==========================================
  // Submodules
  asm_mute_decode i_asm_mute_decode (
    .core_clk(core_clk),
    .nrst(nrst),
    .above_high(mute_above_high),
    .above_mid(mute_above_mid),
    .level_code(mute_level_code)
  );

  asm_speed_select i_asm_speed_select (
    .core_clk(core_clk),
    .nrst(nrst),
    .auto_clk_en(auto_clk_en),
    .auto_mode(auto_mode),
    .sw_mode(sw_mode),
    .speed_mode_monitor(speed_mode_monitor)
  );

  // ==========================================
  // Address decode
  assign hit_left = (req.addr == asm_pkg::ASM_OFF_LEFT_OFS);
  assign hit_right = (req.addr == asm_pkg::ASM_OFF_RIGHT_OFS);
  assign hit_mute = (req.addr == asm_pkg::ASM_OFF_MUTE);
  assign hit_speed = (req.addr == asm_pkg::ASM_OFF_SPEED);
  assign hit_boot = (req.addr == asm_pkg::ASM_OFF_BOOT);
  assign hit_lmag = (req.addr == asm_pkg::ASM_OFF_LEFT_MAG);
  assign hit_rmag = (req.addr == asm_pkg::ASM_OFF_RIGHT_MAG);

  // Composed register values: live monitor bits plus stored reserved bits
  assign val_left = {cal.left_diff_sign, rsv_word[0][6:5],
                     cal.left_cm_comp_value};
  assign val_right = {cal.right_diff_sign, rsv_word[1][6:5],
                      cal.right_cm_comp_value};
  assign val_mute = {rsv_word[2][7:2], mute_level_code};
  assign val_speed = {rsv_word[3][7:3], speed_mode_monitor};
  assign val_boot = {boot_done_flag, rsv_word[4][6:4], power_state_code};

  // Read mux; unmapped offsets read zero
  assign rdata_nxt = hit_left ? val_left :
                     hit_right ? val_right :
                     hit_mute ? val_mute :
                     hit_speed ? val_speed :
                     hit_boot ? val_boot :
                     hit_lmag ? cal.left_diff_magnitude :
                     hit_rmag ? cal.right_diff_magnitude : 8'h00;

  // ==========================================
  // Reserved storage, one entry per register: left, right, mute, speed, boot
  // Monitor bits are masked off here, so a write can never reach them
  assign rsv_hit = {hit_boot, hit_speed, hit_mute, hit_right, hit_left};
  assign rsv_mask = {asm_pkg::ASM_RSV_BOOT_MASK, asm_pkg::ASM_RSV_SPEED_MASK,
                     asm_pkg::ASM_RSV_MUTE_MASK, asm_pkg::ASM_RSV_OFS_MASK,
                     asm_pkg::ASM_RSV_OFS_MASK};

  // Each entry keeps its own flop, so no word has two drivers
  for (genvar g = 0; g < RSV_ENTRIES; g++) begin : g_rsv
    logic [7:0] entry_r;
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        entry_r <= asm_pkg::ASM_RSV_RESET;
      end else if (req.wr && rsv_hit[g]) begin
        entry_r <= req.wdata & rsv_mask[g];
      end
    end
    assign rsv_word[g] = entry_r;
  end

  // Read return one cycle after the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= req.rd ? rdata_nxt : rdata_r;
      rvalid_r <= req.rd;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // ==========================================
  // Checks: offset registers, fields read live at the strobe edge
  // Read data lands one edge after the strobe, so compare with the past
  property p_left_sign;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_left) |=> (rdata[asm_pkg::ASM_SIGN_BIT] == $past(cal.left_diff_sign));
  endproperty
  a_left_sign: assert property (p_left_sign) else $error("left sign wrong");

  property p_left_cm;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_left) |=> (rdata[4:0] == $past(cal.left_cm_comp_value));
  endproperty
  a_left_cm: assert property (p_left_cm) else $error("left cm value wrong");

  property p_right_sign;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_right) |=> (rdata[asm_pkg::ASM_SIGN_BIT] == $past(cal.right_diff_sign));
  endproperty
  a_right_sign: assert property (p_right_sign) else $error("right sign wrong");

  property p_right_cm;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_right) |=> (rdata[4:0] == $past(cal.right_cm_comp_value));
  endproperty
  a_right_cm: assert property (p_right_cm) else $error("right cm value wrong");

  // ==========================================
  // Checks: mute and speed monitors
  // Pin levels pass one register, so look one cycle before the read
  property p_mute_high;
    @(posedge core_clk) disable iff (!nrst)
      (mute_above_high ##1 (req.rd && hit_mute)) |=> (rdata[1:0] == asm_pkg::ASM_MUTE_HIGH);
  endproperty
  a_mute_high: assert property (p_mute_high) else $error("mute high code wrong");

  property p_mute_mid;
    @(posedge core_clk) disable iff (!nrst)
      ((!mute_above_high && mute_above_mid) ##1 (req.rd && hit_mute))
        |=> (rdata[1:0] == asm_pkg::ASM_MUTE_MID);
  endproperty
  a_mute_mid: assert property (p_mute_mid) else $error("mute mid code wrong");

  property p_mute_low;
    @(posedge core_clk) disable iff (!nrst)
      ((!mute_above_high && !mute_above_mid) ##1 (req.rd && hit_mute))
        |=> (rdata[1:0] == asm_pkg::ASM_MUTE_LOW);
  endproperty
  a_mute_low: assert property (p_mute_low) else $error("mute low code wrong");

  // Source selection is registered too, hence the two-cycle look back
  property p_speed_auto;
    @(posedge core_clk) disable iff (!nrst)
      (auto_clk_en ##1 (req.rd && hit_speed)) |=> (rdata[2:0] == $past(auto_mode, 2));
  endproperty
  a_speed_auto: assert property (p_speed_auto) else $error("auto speed wrong");

  property p_speed_sw;
    @(posedge core_clk) disable iff (!nrst)
      (!auto_clk_en ##1 (req.rd && hit_speed)) |=> (rdata[2:0] == $past(sw_mode, 2));
  endproperty
  a_speed_sw: assert property (p_speed_sw) else $error("sw speed wrong");

  property p_speed_err;
    @(posedge core_clk) disable iff (!nrst)
      ((auto_clk_en && auto_mode == asm_pkg::ASM_SPD_AUTO_ERROR) ##1 (req.rd && hit_speed))
        |=> (rdata[2:0] == asm_pkg::ASM_SPD_AUTO_ERROR);
  endproperty
  a_speed_err: assert property (p_speed_err) else $error("auto error code wrong");

  property p_speed_32k;
    @(posedge core_clk) disable iff (!nrst)
      ((!auto_clk_en && sw_mode == asm_pkg::ASM_SPD_32K_SW) ##1 (req.rd && hit_speed))
        |=> (rdata[2:0] == asm_pkg::ASM_SPD_32K_SW);
  endproperty
  a_speed_32k: assert property (p_speed_32k) else $error("sw 32k code wrong");

  // ==========================================
  // Checks: magnitudes, boot flag and power state
  // Magnitudes are full eight-bit reads with no reserved bits
  property p_lmag;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_lmag) |=> (rdata == $past(cal.left_diff_magnitude));
  endproperty
  a_lmag: assert property (p_lmag) else $error("left magnitude wrong");

  property p_rmag;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_rmag) |=> (rdata == $past(cal.right_diff_magnitude));
  endproperty
  a_rmag: assert property (p_rmag) else $error("right magnitude wrong");

  property p_boot;
    @(posedge core_clk) disable iff (!nrst)
      (req.rd && hit_boot) |=> (rdata[asm_pkg::ASM_BOOT_BIT] == $past(boot_done_flag)
        && rdata[3:0] == $past(power_state_code));
  endproperty
  a_boot: assert property (p_boot) else $error("boot or power state wrong");

  // ==========================================
  // Checks: reserved storage
  // A write hit stores the reserved bits, seen in the composed value next cycle
  property p_ro_write;
    @(posedge core_clk) disable iff (!nrst)
      (req.wr && hit_mute) |=> (val_mute[7:2] == $past(req.wdata[7:2]));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("reserved bits not stored");

  property p_left_rsv;
    @(posedge core_clk) disable iff (!nrst)
      (req.wr && hit_left) |=> (val_left[6:5] == $past(req.wdata[6:5]));
  endproperty
  a_left_rsv: assert property (p_left_rsv) else $error("left store wrong");

  property p_right_rsv;
    @(posedge core_clk) disable iff (!nrst)
      (req.wr && hit_right) |=> (val_right[6:5] == $past(req.wdata[6:5]));
  endproperty
  a_right_rsv: assert property (p_right_rsv) else $error("right store wrong");

  property p_speed_rsv;
    @(posedge core_clk) disable iff (!nrst)
      (req.wr && hit_speed) |=> (val_speed[7:3] == $past(req.wdata[7:3]));
  endproperty
  a_speed_rsv: assert property (p_speed_rsv) else $error("speed store wrong");

  property p_boot_rsv;
    @(posedge core_clk) disable iff (!nrst)
      (req.wr && hit_boot) |=> (val_boot[6:4] == $past(req.wdata[6:4]));
  endproperty
  a_boot_rsv: assert property (p_boot_rsv) else $error("boot store wrong");

  // Without a write hit the stored bits stay put, whatever else is on the bus
  property p_left_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(req.wr && hit_left) |=> $stable(val_left[6:5]);
  endproperty
  a_left_hold: assert property (p_left_hold) else $error("left hold wrong");

  property p_right_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(req.wr && hit_right) |=> $stable(val_right[6:5]);
  endproperty
  a_right_hold: assert property (p_right_hold) else $error("right hold wrong");

  property p_mute_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(req.wr && hit_mute) |=> $stable(val_mute[7:2]);
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("mute hold wrong");

  property p_speed_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(req.wr && hit_speed) |=> $stable(val_speed[7:3]);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed hold wrong");

  property p_boot_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(req.wr && hit_boot) |=> $stable(val_boot[6:4]);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot hold wrong");

  // ==========================================
  // Coverage of the main scenarios
  c_read_left: cover property (@(posedge core_clk) req.rd && hit_left);
  c_read_boot_run: cover property (@(posedge core_clk)
    req.rd && hit_boot && power_state_code == asm_pkg::ASM_PWR_RUN);
  c_speed_32k: cover property (@(posedge core_clk)
    !auto_clk_en && sw_mode == asm_pkg::ASM_SPD_32K_SW);
  c_write_mute: cover property (@(posedge core_clk) req.wr && hit_mute);
  c_read_mute_mid: cover property (@(posedge core_clk)
    req.rd && hit_mute && mute_level_code == asm_pkg::ASM_MUTE_MID);
endmodule

// [hdl/asm_pkg.sv]
// Package: offsets, field positions, reset values and encodings of the status monitor bank
package asm_pkg;
  // ==========================================
  // Register offsets (byte addresses on the control port)
  localparam logic [7:0] ASM_OFF_LEFT_OFS = 8'h70;
  localparam logic [7:0] ASM_OFF_RIGHT_OFS = 8'h71;
  localparam logic [7:0] ASM_OFF_MUTE = 8'h72;
  localparam logic [7:0] ASM_OFF_SPEED = 8'h73;
  localparam logic [7:0] ASM_OFF_BOOT = 8'h76;
  localparam logic [7:0] ASM_OFF_LEFT_MAG = 8'h6E;
  localparam logic [7:0] ASM_OFF_RIGHT_MAG = 8'h6F;

  // ==========================================
  // Field positions
  localparam int ASM_SIGN_BIT = 7;
  localparam int ASM_BOOT_BIT = 7;

  // ==========================================
  // Writable reserved masks and reset values
  localparam logic [7:0] ASM_RSV_OFS_MASK = 8'h60;
  localparam logic [7:0] ASM_RSV_MUTE_MASK = 8'hFC;
  localparam logic [7:0] ASM_RSV_SPEED_MASK = 8'hF8;
  localparam logic [7:0] ASM_RSV_BOOT_MASK = 8'h70;
  localparam logic [7:0] ASM_RSV_RESET = 8'h00;

  // ==========================================
  // Encodings
  localparam logic [1:0] ASM_MUTE_HIGH = 2'h3;
  localparam logic [1:0] ASM_MUTE_MID = 2'h1;
  localparam logic [1:0] ASM_MUTE_LOW = 2'h0;
  localparam logic [2:0] ASM_SPD_AUTO_ERROR = 3'h0;
  localparam logic [2:0] ASM_SPD_48K = 3'h3;
  localparam logic [2:0] ASM_SPD_32K_SW = 3'h7;
  localparam logic [3:0] ASM_PWR_RUN = 4'h5;
  localparam logic [3:0] ASM_PWR_STANDBY = 4'h8;

  // Three-level pin decoder result
  typedef enum logic [1:0] {
    ASM_LVL_LOW = 2'h0,
    ASM_LVL_MID = 2'h1,
    ASM_LVL_HIGH = 2'h3
  } asm_level_type;

  // Calibration results from the analog side
  typedef struct packed {
    logic left_diff_sign;
    logic [7:0] left_diff_magnitude;
    logic [4:0] left_cm_comp_value;
    logic right_diff_sign;
    logic [7:0] right_diff_magnitude;
    logic [4:0] right_cm_comp_value;
  } asm_cal_type;

  // Control port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asm_req_type;
endpackage

// [hdl/asm_mute_decode.sv]
// Mute pin level decoder: two comparator outputs to a two-bit level code
`timescale 1ns/1ns
module asm_mute_decode (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic above_high, // Pin at or above 0.7 VDD
  input wire logic above_mid, // Pin at or above 0.3 VDD
  output logic [1:0] level_code // Registered level code
);
  logic [1:0] level_nxt;
  logic [1:0] level_r;

  // ==========================================
  // Decode; high wins so a slow mid comparator cannot hide it
  assign level_nxt = above_high ? asm_pkg::ASM_LVL_HIGH :
                     above_mid ? asm_pkg::ASM_LVL_MID : asm_pkg::ASM_LVL_LOW;

  // Register the code
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level_r <= asm_pkg::ASM_MUTE_LOW;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level_code = level_r;
endmodule

// [hdl/asm_speed_select.sv]
// Speed mode monitor source selection between auto-detect and software value
`timescale 1ns/1ns
module asm_speed_select (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic auto_clk_en, // Automatic clock setup active
  input wire logic [2:0] auto_mode, // Detected mode code
  input wire logic [2:0] sw_mode, // Programmed mode code
  output logic [2:0] speed_mode_monitor // Registered monitor value
);
  logic [2:0] mode_nxt;
  logic [2:0] mode_r;

  // ==========================================
  // Pass codes unchanged; both tables share the code space
  assign mode_nxt = auto_clk_en ? auto_mode : sw_mode;

  // Register the selection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= asm_pkg::ASM_SPD_AUTO_ERROR;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign speed_mode_monitor = mode_r;
endmodule

// [sim/amp_status_monitor_regs_test.sv]
// Self-checking testbench of the status monitor register bank
`timescale 1ns/1ns
module amp_status_monitor_regs_test;
  // ==========================================
  // Stimulus and observation
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  asm_pkg::asm_req_type req = '0;
  logic [7:0] rdata;
  logic rvalid;
  asm_pkg::asm_cal_type cal = '0;
  logic mute_above_high = 1'b0;
  logic mute_above_mid = 1'b0;
  logic auto_clk_en = 1'b1;
  logic [2:0] auto_mode = 3'h0;
  logic [2:0] sw_mode = 3'h0;
  logic boot_done_flag = 1'b0;
  logic [3:0] power_state_code = 4'h0;
  int failures = 0;
  int compares = 0;

  // 250 MHz system clock
  always begin
    #2 core_clk = ~core_clk;
  end

  asm_status_regs i_asm_status_regs (
    .core_clk(core_clk),
    .nrst(nrst),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .cal(cal),
    .mute_above_high(mute_above_high),
    .mute_above_mid(mute_above_mid),
    .auto_clk_en(auto_clk_en),
    .auto_mode(auto_mode),
    .sw_mode(sw_mode),
    .boot_done_flag(boot_done_flag),
    .power_state_code(power_state_code)
  );

  // ==========================================
  // Shared access and compare tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read strobe for one cycle; data and valid land one edge later
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    req.rd <= 1'b1;
    req.addr <= addr;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    check("rvalid", {7'h00, rvalid}, 8'h01);
    check(what, rdata, exp);
    @(posedge core_clk);
    #1;
    check("rvalid_drop", {7'h00, rvalid}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    req.wr <= 1'b1;
    req.addr <= addr;
    req.wdata <= data;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic test_offsets();
    @(posedge core_clk);
    cal <= {1'b1, 8'hA5, 5'h1F, 1'b0, 8'h5A, 5'h0A};
    rd(asm_pkg::ASM_OFF_LEFT_OFS, 8'h9F, "left_offset_status");
    rd(asm_pkg::ASM_OFF_RIGHT_OFS, 8'h0A, "right_offset_status");
    rd(asm_pkg::ASM_OFF_LEFT_MAG, 8'hA5, "left_diff_magnitude");
    rd(asm_pkg::ASM_OFF_RIGHT_MAG, 8'h5A, "right_diff_magnitude");
    @(posedge core_clk);
    cal <= {1'b0, 8'h00, 5'h00, 1'b1, 8'hFF, 5'h1F};
    rd(asm_pkg::ASM_OFF_LEFT_OFS, 8'h00, "left_offset_status");
    rd(asm_pkg::ASM_OFF_RIGHT_OFS, 8'h9F, "right_offset_status");
  endtask

  // High comparator wins over mid, so the top level has both set
  task automatic test_mute();
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      mute_above_high <= (i == 0);
      mute_above_mid <= (i < 2);
      rd(asm_pkg::ASM_OFF_MUTE, (i == 0) ? 8'h03 : (i == 1) ? 8'h01 : 8'h00,
         "mute_level_code");
    end
  endtask

  // Auto and software sources carry opposite codes to tell them apart
  task automatic test_speed();
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge core_clk);
        auto_clk_en <= (m == 0);
        auto_mode <= 3'(i);
        sw_mode <= 3'(7 - i);
        rd(asm_pkg::ASM_OFF_SPEED, (m == 0) ? 8'(i) : 8'(7 - i),
           "speed_mode_monitor");
      end
    end
  endtask

  task automatic test_power();
    @(posedge core_clk);
    boot_done_flag <= 1'b1;
    power_state_code <= asm_pkg::ASM_PWR_RUN;
    rd(asm_pkg::ASM_OFF_BOOT, 8'h85, "boot_power_status");
    @(posedge core_clk);
    boot_done_flag <= 1'b0;
    power_state_code <= asm_pkg::ASM_PWR_STANDBY;
    rd(asm_pkg::ASM_OFF_BOOT, 8'h08, "boot_power_status");
  endtask

  // Monitor bits ignore writes, reserved bits keep them until the next write or reset
  task automatic test_writes();
    @(posedge core_clk);
    cal <= '0;
    mute_above_high <= 1'b0;
    mute_above_mid <= 1'b0;
    auto_clk_en <= 1'b1;
    auto_mode <= 3'h3;
    power_state_code <= 4'h0;
    wr(8'h70, 8'hFF);
    wr(8'h71, 8'hFF);
    wr(8'h72, 8'hFF);
    wr(8'h73, 8'hFF);
    wr(8'h76, 8'hFF);
    wr(8'h6E, 8'hFF);
    wr(8'h80, 8'hFF);
    rd(8'h70, 8'h60, "left_offset_status");
    rd(8'h71, 8'h60, "right_offset_status");
    rd(8'h72, 8'hFC, "mute_level_status");
    rd(8'h73, 8'hFB, "speed_mode_status");
    rd(8'h76, 8'h70, "boot_power_status");
    rd(8'h6E, 8'h00, "left_diff_magnitude");
    rd(8'h80, 8'h00, "unmapped");
    wr(8'h71, 8'h00);
    rd(8'h71, 8'h00, "right_offset_status");
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h72, 8'h00, "mute_level_status");
  endtask

  // ==========================================
  // Verdict and run control
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h70, 8'h00, "left_offset_status");
    test_offsets();
    test_mute();
    test_speed();
    test_power();
    test_writes();
    summarize();
  end
endmodule
